/* File: design/obs_top.sv */
// Option byte loader, access guard, boot select and flash update control.
`timescale 1ns/1ps
`default_nettype none
`include "obs_regs.svh"
module obs_top (
	// Clock, synchronous active-low reset and clock enable.
	input wire logic CORE_CLK,
	input wire logic NRST,
	input wire logic CE,
	// Non-volatile option bytes as presented by the flash at power-up.
	input wire logic [7:0] OPT_A_IN,
	input wire logic [7:0] OPT_B_IN,
	// Reset pin level and strap pins seen while the bytes are caught.
	input wire logic RST_PIN,
	input wire logic P3_STRAP6,
	input wire logic P3_STRAP7,
	input wire logic P4_STRAP3,
	// Register port.
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	// CPU idle entry, one-cycle pulse.
	input wire logic IDLE_ENTER,
	// Boot and flash update control.
	output logic EXEC_LOADER,
	output logic CPU_RESET,
	output logic FLASH_START,
	output logic [7:0] FLASH_TARGET,
	// Code table reads issued by the CPU.
	input wire logic TBL_RD,
	input wire logic TBL_FROM_EXT,
	input wire logic TBL_TO_INT,
	output logic TBL_INT_GRANT,
	output logic TBL_EXT_GRANT,
	output logic TBL_DENY,
	// Reads from the external programmer.
	input wire logic PROG_RD,
	output logic PROG_GRANT,
	output logic PROG_DENY,
	// Fixed settings.
	output logic OPT_VALID,
	output logic DFLASH_LOCKED,
	output logic XTAL_HIGH,
	// PWM generator and pins.
	input wire logic PWM_RUN,
	input wire logic [7:0] PWM_IN,
	output logic [7:0] PWM_OUT,
	output logic [7:0] PWM_OE_N
);
	// Captured option bytes; nothing but the load step writes them.
	logic [7:0] opt_a;
	logic [7:0] opt_b;
	// High once the bytes are caught.
	logic loaded;
	// Boot state and its next value.
	obs_pkg::obs_state_t state;
	obs_pkg::obs_state_t next_state;
	// Software registers.
	logic [7:0] flash_mode_control;
	logic [7:0] flash_target_select;
	// Decoded events.
	logic hw_reboot;
	logic software_reboot;
	logic idle_boot;
	logic flash_go;
	logic tbl_block;
	logic [7:0] next_rdata;

	// Catch both bytes once after reset release; there is no other write path.
	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			opt_a <= `OBS_OPT_RST;
			opt_b <= `OBS_OPT_RST;
			loaded <= 1'b0;
		end else if (CE && !loaded) begin
			opt_a <= OPT_A_IN; // RQ1
			opt_b <= OPT_B_IN; // RQ1
			loaded <= 1'b1;
		end
	end

	// Straps are judged against the byte being caught, in the same cycle.
	assign hw_reboot = RST_PIN &&
		((!OPT_A_IN[`OBS_A_P3RB] && !P3_STRAP6 && !P3_STRAP7) || // RQ5
		(!OPT_A_IN[`OBS_A_P4RB] && !P4_STRAP3)); // RQ6

	// The reboot command acts as the write lands; it never needs to be stored.
	assign software_reboot = WR && ADDR == `OBS_ADDR_FMC && WDATA == `OBS_FMC_SW_REBOOT && state != obs_pkg::OBS_LOAD; // RQ15
	assign idle_boot = IDLE_ENTER && state == obs_pkg::OBS_RUN_APP && flash_mode_control == `OBS_FMC_LDR_BOOT; // RQ14

	// An update starts only for a valid mode: 01h anywhere, 03h once in the loader.
	assign flash_go = IDLE_ENTER && state != obs_pkg::OBS_LOAD && // RQ17
		(flash_mode_control == `OBS_FMC_APP_UPD || // RQ16
		(flash_mode_control == `OBS_FMC_LDR_BOOT && state == obs_pkg::OBS_RUN_LDR));

	// Next boot state.
	always_comb begin
		next_state = state;
		case (state)
			obs_pkg::OBS_LOAD: begin
				next_state = hw_reboot ? obs_pkg::OBS_RUN_LDR : obs_pkg::OBS_RUN_APP; // RQ5 RQ6
			end
			obs_pkg::OBS_RUN_APP: begin
				if (idle_boot) begin
					next_state = obs_pkg::OBS_RUN_LDR; // RQ14
				end
			end
			obs_pkg::OBS_RUN_LDR: begin
				if (software_reboot) begin
					next_state = obs_pkg::OBS_RUN_APP; // RQ15
				end
			end
			default: begin
				next_state = obs_pkg::OBS_LOAD;
			end
		endcase
	end

	// Boot state, execution source and the restart pulse.
	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			state <= obs_pkg::OBS_LOAD;
			EXEC_LOADER <= 1'b0;
			CPU_RESET <= 1'b0;
		end else if (CE) begin
			state <= next_state;
			EXEC_LOADER <= next_state == obs_pkg::OBS_RUN_LDR;
			CPU_RESET <= idle_boot || software_reboot; // RQ14 RQ15
		end
	end

	// Mode register; a restart clears it since the CPU comes back from reset.
	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			flash_mode_control <= `OBS_REG_RST;
		end else if (CE) begin
			if (idle_boot || software_reboot) begin
				flash_mode_control <= `OBS_REG_RST;
			end else if (WR && ADDR == `OBS_ADDR_FMC) begin
				flash_mode_control <= WDATA;
			end
		end
	end

	// Target register and the update start toward the flash controller.
	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			flash_target_select <= `OBS_REG_RST;
			FLASH_START <= 1'b0;
			FLASH_TARGET <= `OBS_REG_RST;
		end else if (CE) begin
			if (WR && ADDR == `OBS_ADDR_FTS) begin
				flash_target_select <= WDATA;
			end
			FLASH_START <= flash_go; // RQ16 RQ17
			if (flash_go) begin
				FLASH_TARGET <= flash_target_select; // RQ17
			end
		end
	end

	// Read mux; the option copies read as zero while the lock is on.
	always_comb begin
		next_rdata = 8'h00;
		if (RD) begin
			case (ADDR)
				`OBS_ADDR_FMC: next_rdata = flash_mode_control;
				`OBS_ADDR_FTS: next_rdata = flash_target_select;
				`OBS_ADDR_STAT: next_rdata = {4'h0, !opt_a[`OBS_A_LOCK], DFLASH_LOCKED, EXEC_LOADER, loaded};
				`OBS_ADDR_OPTA: next_rdata = opt_a[`OBS_A_LOCK] ? opt_a : 8'h00; // RQ2
				`OBS_ADDR_OPTB: next_rdata = opt_a[`OBS_A_LOCK] ? opt_b : 8'h00; // RQ2
				default: next_rdata = 8'h00;
			endcase
		end
	end

	// Read data stands only in the cycle after the strobe.
	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			RDATA <= 8'h00;
		end else if (CE) begin
			RDATA <= next_rdata;
		end
	end

	// External code reaching internal flash is blocked when table reads are inhibited.
	assign tbl_block = TBL_FROM_EXT && TBL_TO_INT && !opt_a[`OBS_A_TBL]; // RQ3

	// Access answers, one cycle after the request; all refused before the bytes are caught.
	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			TBL_INT_GRANT <= 1'b0;
			TBL_EXT_GRANT <= 1'b0;
			TBL_DENY <= 1'b0;
			PROG_GRANT <= 1'b0;
			PROG_DENY <= 1'b0;
		end else if (CE) begin
			TBL_INT_GRANT <= TBL_RD && loaded && TBL_TO_INT && !tbl_block; // RQ3
			TBL_EXT_GRANT <= TBL_RD && loaded && !TBL_TO_INT;
			TBL_DENY <= TBL_RD && (!loaded || tbl_block); // RQ3
			PROG_GRANT <= PROG_RD && loaded && opt_a[`OBS_A_LOCK]; // RQ2
			PROG_DENY <= PROG_RD && (!loaded || !opt_a[`OBS_A_LOCK]); // RQ2
		end
	end

	// Fixed settings; data flash counts as locked until the byte is known.
	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			OPT_VALID <= 1'b0;
			DFLASH_LOCKED <= 1'b1;
			XTAL_HIGH <= 1'b0;
		end else if (CE) begin
			OPT_VALID <= loaded;
			DFLASH_LOCKED <= !loaded || !opt_a[`OBS_A_DFL]; // RQ4
			XTAL_HIGH <= loaded && opt_a[`OBS_A_XTAL]; // RQ7
		end
	end

	// PWM pins driven from the second option byte.
	obs_pwm_gate #(
		.CH(8)
	) u_pwm (
		.clk(CORE_CLK),
		.nrst(NRST),
		.ce(CE),
		.cpu_reset(CPU_RESET),
		.loaded(loaded),
		.opt_b(opt_b),
		.run(PWM_RUN),
		.pwm_in(PWM_IN),
		.pwm_out(PWM_OUT),
		.pwm_oe_n(PWM_OE_N)
	);

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!NRST);

	// Single-cycle sequences for the boot transitions.
	sequence s_idle_boot;
		CE && idle_boot;
	endsequence
	sequence s_into_loader;
		CPU_RESET && EXEC_LOADER;
	endsequence

	chk_options_fixed: assert property (loaded && $past(loaded) |-> $stable(opt_a) && $stable(opt_b)) // RQ1
		else $error("option bytes changed after load");
	chk_prog_lock: assert property (CE && PROG_RD && loaded && !opt_a[`OBS_A_LOCK] |=> PROG_DENY && !PROG_GRANT) // RQ2
		else $error("locked flash read granted");
	chk_table_restrict: assert property (CE && TBL_RD && loaded && tbl_block |=> TBL_DENY && !TBL_INT_GRANT) // RQ3
		else $error("external table read reached internal flash");
	chk_dflash_lock: assert property (CE && loaded && !opt_a[`OBS_A_DFL] |=> DFLASH_LOCKED) // RQ4
		else $error("data flash not locked");
	chk_strap_boot: assert property (CE && state == obs_pkg::OBS_LOAD && hw_reboot |=> EXEC_LOADER) // RQ5 RQ6
		else $error("strap reboot did not select loader");
	chk_idle_boot: assert property (s_idle_boot |=> s_into_loader ##1 !CPU_RESET) // RQ14
		else $error("idle with 03h did not restart into loader");
	chk_sw_reboot: assert property (CE && software_reboot |=> CPU_RESET && !EXEC_LOADER && flash_mode_control == 8'h00) // RQ15
		else $error("software reboot did not return to application");
	chk_update_start: assert property (CE && flash_go |=> FLASH_START && FLASH_TARGET == $past(flash_target_select)) // RQ16 RQ17
		else $error("update start or target wrong");
	chk_no_bad_start: assert property (CE && IDLE_ENTER && flash_mode_control != `OBS_FMC_APP_UPD && // RQ17
		flash_mode_control != `OBS_FMC_LDR_BOOT |=> !FLASH_START)
		else $error("update started with invalid mode");

	// An update run from the application keeps the CPU where it is: no restart, no loader.
	sequence s_app_update;
		CE && IDLE_ENTER && state == obs_pkg::OBS_RUN_APP && flash_mode_control == `OBS_FMC_APP_UPD;
	endsequence
	sequence s_start_only;
		FLASH_START && !CPU_RESET && !EXEC_LOADER;
	endsequence
	chk_app_update: assert property (s_app_update |=> s_start_only) // RQ16
		else $error("update from application did not start cleanly");

	// The open cases are checked too, so a guard that refuses everything cannot pass.
	chk_prog_open: assert property (CE && PROG_RD && loaded && opt_a[`OBS_A_LOCK] |=> // RQ2
		PROG_GRANT && !PROG_DENY)
		else $error("unlocked flash read refused");
	chk_table_open: assert property (CE && TBL_RD && loaded && !TBL_FROM_EXT && TBL_TO_INT |=> // RQ3
		TBL_INT_GRANT && !TBL_DENY)
		else $error("internal table read refused");
	chk_dflash_open: assert property (CE && loaded && opt_a[`OBS_A_DFL] |=> !DFLASH_LOCKED) // RQ4
		else $error("data flash locked with lock bit set");
	chk_app_default: assert property (CE && state == obs_pkg::OBS_LOAD && !hw_reboot |=> !EXEC_LOADER) // RQ5 RQ6
		else $error("loader selected without a strap reboot");

	// Option copies must read as zero under the lock, since readback is an access path too.
	chk_option_blank: assert property (CE && RD && !opt_a[`OBS_A_LOCK] && // RQ2
		(ADDR == `OBS_ADDR_OPTA || ADDR == `OBS_ADDR_OPTB) |=> RDATA == 8'h00)
		else $error("option byte readable while locked");
	// Read data answers only a read, and carries the register as it stood when read.
	chk_read_quiet: assert property (CE && !RD |=> RDATA == 8'h00)
		else $error("read data without a read");
	chk_mode_read: assert property (CE && RD && ADDR == `OBS_ADDR_FMC |=> RDATA == $past(flash_mode_control))
		else $error("mode register read back wrong");
	// Every access answer is a reply; a stray pulse would look like a grant to the CPU.
	chk_access_quiet: assert property (CE && !TBL_RD && !PROG_RD |=>
		!TBL_INT_GRANT && !TBL_EXT_GRANT && !TBL_DENY && !PROG_GRANT && !PROG_DENY)
		else $error("access answer without a request");
	// A low enable must hold EXEC_LOADER, CPU_RESET, FLASH_START and RDATA where they stand.
	chk_freeze_hold: assert property (!CE |=> $stable(EXEC_LOADER) && $stable(CPU_RESET) &&
		$stable(FLASH_START) && $stable(RDATA))
		else $error("outputs moved while the clock enable was low");
endmodule // obs_top
`default_nettype wire

/* File: design/obs_regs.svh */
// Register offsets, field positions, reset values and command codes of the option and boot block.
// Notes on behaviour
// RQ1: Option bytes load once, never rewritable.
// RQ2: Lock bit low refuses flash reads.
// RQ3: Inhibit low: external table reads stay external.
// RQ4: Data flash lock bit is active low.
// RQ5: Port 3 straps low boot loader flash.
// RQ6: Port 4 strap low boots loader flash.
// RQ7: Programmer sets crystal bit above 24MHz.
// RQ8: Option B bit 0 enables odd PWM.
// RQ9: Option B bit 1 enables even PWM.
// RQ10: Option B bit 2 sets odd start level.
// RQ11: Option B bit 3 sets even start level.
// RQ12: Option B bit 6 enables channel 6.
// RQ13: Option B bit 7 enables channel 7.
// RQ14: Mode 03h at idle boots loader.
// RQ15: Writing 83h reboots into application flash.
// RQ16: Mode 01h at idle updates, keeps running.
// RQ17: Target register picks bank; valid mode starts.
`ifndef OBS_REGS_SVH
`define OBS_REGS_SVH
`define OBS_ADDR_FMC 8'h00
`define OBS_ADDR_FTS 8'h01
`define OBS_ADDR_STAT 8'h02
`define OBS_ADDR_OPTA 8'h03
`define OBS_ADDR_OPTB 8'h04
`define OBS_A_LOCK 0
`define OBS_A_TBL 1
`define OBS_A_DFL 2
`define OBS_A_P3RB 4
`define OBS_A_P4RB 5
`define OBS_A_XTAL 7
`define OBS_B_ODD_EN 0
`define OBS_B_EVEN_EN 1
`define OBS_B_ODD_POL 2
`define OBS_B_EVEN_POL 3
`define OBS_B_CH6_EN 6
`define OBS_B_CH7_EN 7
`define OBS_OPT_RST 8'hFF
`define OBS_REG_RST 8'h00
`define OBS_FMC_APP_UPD 8'h01
`define OBS_FMC_LDR_BOOT 8'h03
`define OBS_FMC_SW_REBOOT 8'h83
`endif

/* File: design/obs_pkg.sv */
// Types shared by the option and boot block.
`default_nettype none
package obs_pkg;
	// Where the CPU executes from; load is the window in which the option bytes are caught.
	typedef enum logic [1:0] {OBS_LOAD, OBS_RUN_APP, OBS_RUN_LDR} obs_state_t;
endpackage
`default_nettype wire

/* File: design/obs_pwm_gate.sv */
// PWM pin gating and start levels taken from the second option byte.
`timescale 1ns/1ps
`default_nettype none
`include "obs_regs.svh"
module obs_pwm_gate #(
	parameter int CH = 8
) (
	// Clock, reset and enable.
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	// Restart of the CPU, which brings back the start levels.
	input wire logic cpu_reset,
	// Option byte state.
	input wire logic loaded,
	input wire logic [7:0] opt_b,
	// Generator side.
	input wire logic run,
	input wire logic [CH-1:0] pwm_in,
	// Pin side; enable low while the pin is driven.
	output logic [CH-1:0] pwm_out,
	output logic [CH-1:0] pwm_oe_n
);
	// Set once the generator runs; until then pins show the start level.
	logic started;

	// The start flag is cleared by every CPU restart so the start level returns.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			started <= 1'b0;
		end else if (ce) begin
			if (cpu_reset) begin
				started <= 1'b0;
			end else if (run) begin
				started <= 1'b1;
			end
		end
	end

	// One copy of the pin logic per channel.
	for (genvar i = 0; i < CH; i++) begin : g_ch
		// Channels 6 and 7 have their own enables; the rest share by parity.
		logic en_n;
		logic init;
		assign en_n = (i == 6) ? opt_b[`OBS_B_CH6_EN] : // RQ12
			(i == 7) ? opt_b[`OBS_B_CH7_EN] : // RQ13
			(i % 2 == 1) ? opt_b[`OBS_B_ODD_EN] : opt_b[`OBS_B_EVEN_EN]; // RQ8 RQ9
		assign init = (i % 2 == 1) ? opt_b[`OBS_B_ODD_POL] : opt_b[`OBS_B_EVEN_POL]; // RQ10 RQ11

		// Pins stay undriven until the option byte has been caught.
		always_ff @(posedge clk) begin
			if (!nrst) begin
				pwm_out[i] <= 1'b0;
				pwm_oe_n[i] <= 1'b1;
			end else if (ce) begin
				pwm_out[i] <= (started && !cpu_reset) ? pwm_in[i] : init; // RQ10 RQ11
				pwm_oe_n[i] <= !loaded || en_n; // RQ8 RQ9 RQ12 RQ13
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	chk_pwm_enable_gate: assert property (ce && loaded && opt_b[`OBS_B_ODD_EN] |=> pwm_oe_n[1] && pwm_oe_n[3]) // RQ8
		else $error("odd PWM pin driven while disabled");
	chk_pwm_even_gate: assert property (ce && loaded && !opt_b[`OBS_B_EVEN_EN] |=> !pwm_oe_n[0]) // RQ9
		else $error("even PWM pin not driven while enabled");
	chk_pwm_start_level: assert property (ce && cpu_reset |=> pwm_out[1] == $past(opt_b[`OBS_B_ODD_POL])) // RQ10
		else $error("odd PWM start level wrong");
endmodule // obs_pwm_gate
`default_nettype wire

/* File: dv/obs_prog_model.sv */
// Model of the programmer, the option byte flash and the reset and strap pins.
`timescale 1ns/1ps
`default_nettype none
module obs_prog_model (
	// Clock and bench controls.
	input wire logic clk,
	input wire logic [7:0] cfg_a,
	input wire logic [7:0] cfg_b,
	input wire logic [3:0] cfg_pins,
	input wire logic rd_req,
	input wire logic caught,
	// Lines toward the block.
	output logic [7:0] opt_a,
	output logic [7:0] opt_b,
	output logic [3:0] pins,
	output logic prog_rd
);
	// Bytes show only until caught; then the lines churn, so a late or repeated capture is seen.
	// The core clock is 25 MHz, so the crystal range bit is always set.
	always_ff @(posedge clk) begin
		if (!caught) begin
			opt_a <= {1'b1, cfg_a[6:0]};
			opt_b <= cfg_b;
			pins <= cfg_pins;
		end else begin
			opt_a <= ~opt_a;
			opt_b <= ~opt_b;
			pins <= ~pins;
		end
	end
	// A programmer read lasts one cycle.
	always_ff @(posedge clk) prog_rd <= rd_req;
endmodule // obs_prog_model
`default_nettype wire

/* File: dv/tb_obs_top.sv */
// Self-checking bench for the option byte and boot select block.
`timescale 1ns/1ps
`default_nettype none
`define OBS_CMP(n, e, v) begin checks++; if ((v) !== (e)) begin error_cnt++; $display("ERROR %s exp %h got %h", n, e, v); end end
module tb_obs_top;
	// An expected result: which output, its value and the cycle it is due in.
	typedef struct {int sel; logic [7:0] exp; int due;} obs_note_t;
	logic CORE_CLK = 1'b0, NRST = 1'b0, WR = 1'b0, RD = 1'b0, IDLE_ENTER = 1'b0, TBL_RD = 1'b0, rd_req = 1'b0;
	logic TBL_FROM_EXT = 1'b0, TBL_TO_INT = 1'b0, PWM_RUN = 1'b0, CE = 1'b1;
	logic [7:0] ADDR = 8'h00, WDATA = 8'h00, PWM_IN = 8'h00, cfg_a = 8'hFF, cfg_b = 8'hFF;
	logic [3:0] cfg_pins = 4'h0, pins;
	logic [7:0] opt_a, opt_b, RDATA, FLASH_TARGET, PWM_OUT, PWM_OE_N;
	logic PROG_RD, EXEC_LOADER, CPU_RESET, FLASH_START, TBL_INT_GRANT, TBL_EXT_GRANT, TBL_DENY;
	logic PROG_GRANT, PROG_DENY, OPT_VALID, DFLASH_LOCKED, XTAL_HIGH;
	obs_note_t notes[$];
	int cyc = 0, checks = 0, error_cnt = 0;
	string nm[7] = '{"RDATA", "boot", "TARGET", "grants", "PWM_OUT", "PWM_OE_N", "flags"};
	obs_prog_model prog_u (.clk(CORE_CLK), .cfg_a(cfg_a), .cfg_b(cfg_b), .cfg_pins(cfg_pins), .rd_req(rd_req),
		.caught(OPT_VALID), .opt_a(opt_a), .opt_b(opt_b), .pins(pins), .prog_rd(PROG_RD));
	// The clock enable is driven so that one scenario can freeze the block.
	obs_top dut_u (.CORE_CLK(CORE_CLK), .NRST(NRST), .CE(CE), .OPT_A_IN(opt_a), .OPT_B_IN(opt_b),
		.RST_PIN(pins[3]), .P3_STRAP6(pins[2]), .P3_STRAP7(pins[1]), .P4_STRAP3(pins[0]), .ADDR(ADDR),
		.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IDLE_ENTER(IDLE_ENTER), .EXEC_LOADER(EXEC_LOADER),
		.CPU_RESET(CPU_RESET), .FLASH_START(FLASH_START), .FLASH_TARGET(FLASH_TARGET), .TBL_RD(TBL_RD),
		.TBL_FROM_EXT(TBL_FROM_EXT), .TBL_TO_INT(TBL_TO_INT), .TBL_INT_GRANT(TBL_INT_GRANT),
		.TBL_EXT_GRANT(TBL_EXT_GRANT), .TBL_DENY(TBL_DENY), .PROG_RD(PROG_RD), .PROG_GRANT(PROG_GRANT),
		.PROG_DENY(PROG_DENY), .OPT_VALID(OPT_VALID), .DFLASH_LOCKED(DFLASH_LOCKED), .XTAL_HIGH(XTAL_HIGH),
		.PWM_RUN(PWM_RUN), .PWM_IN(PWM_IN), .PWM_OUT(PWM_OUT), .PWM_OE_N(PWM_OE_N));
	initial forever #20 CORE_CLK = ~CORE_CLK;
	// Packs the watched outputs into groups.
	function automatic logic [7:0] out_of(input int s);
		case (s)
			0: return RDATA;
			1: return {5'h00, EXEC_LOADER, CPU_RESET, FLASH_START};
			2: return FLASH_TARGET;
			3: return {3'h0, TBL_INT_GRANT, TBL_EXT_GRANT, TBL_DENY, PROG_GRANT, PROG_DENY};
			4: return PWM_OUT;
			5: return PWM_OE_N;
			default: return {5'h00, OPT_VALID, DFLASH_LOCKED, XTAL_HIGH};
		endcase
	endfunction
	// Files a note in due order; lat is cycles after the edge on which the request is driven.
	task automatic note(input int s, input logic [7:0] e, input int lat);
		int i;
		i = notes.size();
		while (i > 0 && notes[i - 1].due > cyc + 1 + lat) i--;
		notes.insert(i, obs_note_t'{s, e, cyc + 1 + lat});
	endtask
	// One bus cycle: 1 write, 2 read, 3 idle entry, 4 table read, 5 programmer read, 0 nothing.
	task automatic op(input int k, input logic [7:0] a, input logic [7:0] d);
		@(posedge CORE_CLK);
		WR <= (k == 1);
		RD <= (k == 2);
		IDLE_ENTER <= (k == 3);
		TBL_RD <= (k == 4);
		rd_req <= (k == 5);
		TBL_FROM_EXT <= a[1];
		TBL_TO_INT <= a[0];
		ADDR <= a;
		WDATA <= d;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		op(2, a, 8'h00);
		note(0, e, 1);
	endtask
	// Power up with given bytes and pins, then check every fixed setting.
	task automatic power_up(input logic [7:0] a, input logic [7:0] b, input logic [3:0] p);
		logic [7:0] ea;
		logic bt;
		ea = {1'b1, a[6:0]};
		bt = p[3] && ((!ea[4] && p[2:1] == 2'b00) || (!ea[5] && !p[0]));
		op(0, 8'h00, 8'h00);
		cfg_a <= a;
		cfg_b <= b;
		cfg_pins <= p;
		NRST <= 1'b0;
		PWM_RUN <= 1'b0;
		repeat (5) op(0, 8'h00, 8'h00);
		NRST <= 1'b1;
		repeat (3) op(0, 8'h00, 8'h00);
		note(6, {5'h00, 1'b1, !ea[2], 1'b1}, 0);
		note(1, {5'h00, bt, 2'b00}, 0);
		note(5, {b[7], b[6], b[0], b[1], b[0], b[1], b[0], b[1]}, 0);
		note(4, {4{b[2], b[3]}}, 0);
		rd(8'h02, {4'h0, !ea[0], !ea[2], bt, 1'b1});
		op(1, 8'h03, ~ea);
		op(1, 8'h04, ~b);
		rd(8'h03, ea[0] ? ea : 8'h00);
		rd(8'h04, ea[0] ? b : 8'h00);
		rd(8'h3C, 8'h00);
		rd(8'h00, 8'h00);
		op(5, 8'h00, 8'h00);
		note(3, ea[0] ? 8'h02 : 8'h01, 2);
		op(0, 8'h00, 8'h00);
		for (int k = 0; k < 4; k++) begin
			op(4, 8'(k), 8'h00);
			note(3, (k == 3 && !ea[1]) ? 8'h04 : (k[0] ? 8'h10 : 8'h08), 1);
		end
		$display("test power_up %h %h %h done", a, b, p);
	endtask
	// Loader boot, loader update, reboot and in-application update, with PWM restarts.
	task automatic boot_flow();
		logic [7:0] t, r;
		t = 8'($urandom);
		r = 8'($urandom);
		op(0, 8'h00, 8'h00);
		PWM_RUN <= 1'b1;
		PWM_IN <= r;
		note(4, r, 2);
		op(1, 8'h00, 8'h02);
		op(3, 8'h00, 8'h00);
		note(1, 8'h00, 1);
		op(1, 8'h01, t);
		op(1, 8'h00, 8'h03);
		PWM_RUN <= 1'b0;
		op(3, 8'h00, 8'h00);
		note(1, 8'h06, 1);
		note(1, 8'h04, 2);
		note(4, {4{cfg_b[2], cfg_b[3]}}, 3);
		rd(8'h00, 8'h00);
		op(1, 8'h00, 8'h03);
		op(3, 8'h00, 8'h00);
		note(1, 8'h05, 1);
		note(2, t, 2);
		op(1, 8'h00, 8'h83);
		note(1, 8'h02, 1);
		note(1, 8'h00, 2);
		rd(8'h00, 8'h00);
		op(1, 8'h01, r);
		op(1, 8'h00, 8'h01);
		op(3, 8'h00, 8'h00);
		note(1, 8'h01, 1);
		note(1, 8'h00, 2);
		note(2, r, 2);
		// A frozen cycle must swallow an idle entry that would otherwise start an update.
		op(0, 8'h00, 8'h00);
		op(3, 8'h00, 8'h00);
		CE <= 1'b0;
		note(1, 8'h00, 1);
		op(0, 8'h00, 8'h00);
		CE <= 1'b1;
		repeat (3) op(0, 8'h00, 8'h00);
		$display("test boot_flow done");
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Takes each due note off the queue once the outputs have settled.
	initial begin
		forever begin
			@(posedge CORE_CLK);
			#1;
			cyc++;
			while (notes.size() > 0 && notes[0].due <= cyc) begin
				`OBS_CMP(nm[notes[0].sel], notes[0].exp, out_of(notes[0].sel))
				void'(notes.pop_front());
			end
		end
	end
	// The tests need some 200 cycles; twenty times that means a hang.
	initial begin
		repeat (4000) @(posedge CORE_CLK);
		error_cnt++;
		tally_and_finish();
	end
	initial begin
		void'($urandom(32'h2EA0));
		power_up(8'hFF, 8'hFF, 4'h0);
		boot_flow();
		power_up(8'h00, 8'h00, 4'h8);
		repeat (6) power_up(8'($urandom), 8'($urandom), 4'($urandom));
		repeat (3) op(0, 8'h00, 8'h00);
		tally_and_finish();
	end
endmodule // tb_obs_top
`default_nettype wire
